/* File: shared/lsd_pkg.sv */
// Package: register map, field layout and scan constants of the LED/LCD scan driver
`default_nettype none

package lsd_pkg;

  // ----------------------------------------------------------------
  // Bus and array sizes
  // ----------------------------------------------------------------
  localparam int ADDR_W    = 6;
  localparam int DATA_W    = 8;
  localparam int NUM_DATA  = 32;
  localparam int NUM_COM   = 8;
  localparam int MAX_DIG   = 15;
  localparam int DIV_W     = 12;
  localparam int PRE_W     = 8;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_DATA_LAST = 6'h1f;
  localparam logic [ADDR_W-1:0] ADDR_DIVL      = 6'h20;
  localparam logic [ADDR_W-1:0] ADDR_DIVH      = 6'h21;
  localparam logic [ADDR_W-1:0] ADDR_CFG       = 6'h22;
  localparam logic [ADDR_W-1:0] ADDR_SCAN      = 6'h23;
  localparam logic [ADDR_W-1:0] ADDR_POL       = 6'h24;
  localparam logic [ADDR_W-1:0] ADDR_STAT      = 6'h25;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int DIVH_MODE_LSB  = 5;
  localparam int CFG_BLANK_BIT  = 3;
  localparam int POL_SEG_BIT    = 7;
  localparam int POL_COM_BIT    = 6;
  localparam int STAT_PHASE_BIT = 7;

  // ----------------------------------------------------------------
  // Scan constants
  // ----------------------------------------------------------------
  localparam logic [PRE_W-1:0] PRE_MAX      = 8'hff;
  localparam logic [3:0]       DIG_CNT_MAX  = 4'he;
  localparam logic [7:0]       BYTE_ZERO    = 8'h00;

  // Display mode field
  typedef enum logic [1:0] {
    LSD_MODE_OFF    = 2'b00,
    LSD_MODE_LCD    = 2'b01,
    LSD_MODE_EXT    = 2'b10,
    LSD_MODE_DIRECT = 2'b11
  } lsd_mode_e;

  // Software configuration carried as one bundle
  typedef struct packed {
    lsd_mode_e        mode;
    logic [DIV_W-1:0] div;
    logic             display_blank;
    logic             common_polarity;
    logic             segment_polarity;
    logic [3:0]       scan_sel;
    logic [5:0]       led_brightness_level;
  } lsd_cfg_s;

  localparam lsd_cfg_s CFG_RESET = '0;

endpackage

`default_nettype wire

/* File: rtl/lsd_scan_driver.sv */
// Top: LED direct/external drive and LCD common scan controller with register port
//
// Function
// - Mode 11 selects LED direct drive
// - Direct drive: eight segments, fifteen digits max
// - Data bytes on commons, segment pins scanned
// - Each digit lit one slot per frame
// - Commons carry pattern, segment pins pick digit
// - Mode 10 selects LED external drive
// - External: commons scanned, duty from duty field
// - External matrix up to 4x32 or 8x28
// - LCD 1/6 duty frame is twelve clocks
// - Data bit n driven in common slot n
// - Direct digit count is field plus one, capped at fifteen
// - Blank forces outputs off, scan keeps running
// - Common polarity (external mode only) zero high, one low active
//
// Design decisions made here: strobed register access and the placing of the registers.
`default_nettype none

module lsd_scan_driver
  import lsd_pkg::*;
#(
  parameter int NUM_SEG = 32
)(
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  // Register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  // Display pins
  output logic      [NUM_COM-1:0] com_out,
  output logic      [NUM_SEG-1:0] seg_out,
  output logic                    frame_pulse
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------

  // Index of the last scan slot for the configured mode
  function automatic logic [3:0] last_slot(input lsd_cfg_s c);
    logic [3:0] r;
    r = {1'b0, c.scan_sel[2:0]};
    if (c.mode == LSD_MODE_DIRECT)
    begin
      // Field value 15 would ask for a sixteenth digit; clamp to fifteen
      r = (c.scan_sel > DIG_CNT_MAX) ? DIG_CNT_MAX : c.scan_sel;
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] data_r   [NUM_DATA];
  logic [DATA_W-1:0] data_nxt [NUM_DATA];
  lsd_cfg_s          cfg_r;
  lsd_cfg_s          cfg_nxt;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;

  // Scan state
  logic [PRE_W-1:0]  pre_r;
  logic [PRE_W-1:0]  pre_nxt;
  logic [DIV_W-1:0]  div_cnt_r;
  logic [DIV_W-1:0]  div_cnt_nxt;
  logic [3:0]        slot_r;
  logic [3:0]        slot_nxt;
  logic              phase_r;
  logic              phase_nxt;
  logic              tick;
  logic              wrap;

  // Output state
  logic [NUM_COM-1:0] com_r;
  logic [NUM_COM-1:0] com_nxt;
  logic [NUM_SEG-1:0] seg_r;
  logic [NUM_SEG-1:0] seg_nxt;
  logic               frame_r;
  logic               frame_nxt;
  logic               pwm_on;

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------

  // Writes land in one cycle; reads answer in the following cycle only
  always_comb
  begin
    data_nxt  = data_r;
    cfg_nxt   = cfg_r;
    rdata_nxt = BYTE_ZERO;
    if (reg_wr)
    begin
      if (reg_addr <= ADDR_DATA_LAST)
      begin
        data_nxt[reg_addr[4:0]] = reg_wdata;
      end
      else
      begin
        unique case (reg_addr)
          ADDR_DIVL: cfg_nxt.div[7:0] = reg_wdata;
          ADDR_DIVH:
          begin
            cfg_nxt.div[DIV_W-1:8] = reg_wdata[3:0];
            cfg_nxt.mode = lsd_mode_e'(reg_wdata[DIVH_MODE_LSB+:2]);
          end
          ADDR_CFG:  cfg_nxt.display_blank = reg_wdata[CFG_BLANK_BIT];
          ADDR_SCAN: cfg_nxt.scan_sel = reg_wdata[3:0];
          ADDR_POL:
          begin
            cfg_nxt.segment_polarity     = reg_wdata[POL_SEG_BIT];
            cfg_nxt.common_polarity      = reg_wdata[POL_COM_BIT];
            cfg_nxt.led_brightness_level = reg_wdata[5:0];
          end
          default: ;
        endcase
      end
    end
    if (reg_rd)
    begin
      if (reg_addr <= ADDR_DATA_LAST)
      begin
        rdata_nxt = data_r[reg_addr[4:0]];
      end
      else
      begin
        unique case (reg_addr)
          ADDR_DIVL: rdata_nxt = cfg_r.div[7:0];
          ADDR_DIVH: rdata_nxt = {1'b0, cfg_r.mode, 1'b0, cfg_r.div[DIV_W-1:8]};
          ADDR_CFG:  rdata_nxt = {4'h0, cfg_r.display_blank, 3'h0};
          ADDR_SCAN: rdata_nxt = {4'h0, cfg_r.scan_sel};
          ADDR_POL:  rdata_nxt = {cfg_r.segment_polarity, cfg_r.common_polarity,
                                  cfg_r.led_brightness_level};
          ADDR_STAT: rdata_nxt = {phase_r, 3'h0, slot_r};
          default:   rdata_nxt = BYTE_ZERO;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < NUM_DATA; i++)
      begin
        data_r[i] <= BYTE_ZERO;
      end
      cfg_r   <= CFG_RESET;
      rdata_r <= BYTE_ZERO;
    end
    else
    begin
      data_r  <= data_nxt;
      cfg_r   <= cfg_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Display clock and slot sequencer
  // ----------------------------------------------------------------

  // Display clock is clk_sys / 256 / (div + 1); the prescaler also paces the PWM
  // Compare is >= so lowering div mid-count never waits for a 12-bit wrap
  assign tick = (pre_r == PRE_MAX) && (div_cnt_r >= cfg_r.div);
  assign wrap = (slot_r >= last_slot(cfg_r));

  // Slots step only on a display clock tick, from slot 0 up to the last one
  always_comb
  begin
    pre_nxt     = pre_r + 1'b1;
    div_cnt_nxt = div_cnt_r;
    slot_nxt    = slot_r;
    phase_nxt   = phase_r;
    frame_nxt   = 1'b0;
    if (pre_r == PRE_MAX)
    begin
      div_cnt_nxt = tick ? '0 : div_cnt_r + 1'b1;
    end
    if (cfg_r.mode == LSD_MODE_OFF)
    begin
      slot_nxt  = '0;
      phase_nxt = 1'b0;
    end
    else if (tick)
    begin
      if (wrap)
      begin
        slot_nxt  = '0;
        phase_nxt = ~phase_r;
        // LCD frame spans both drive phases, so 1/6 duty gives twelve ticks
        if (cfg_r.mode != LSD_MODE_LCD || phase_r)
        begin
          frame_nxt = 1'b1;
        end
      end
      else
      begin
        slot_nxt = slot_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      pre_r     <= '0;
      div_cnt_r <= '0;
      slot_r    <= '0;
      phase_r   <= 1'b0;
      frame_r   <= 1'b0;
    end
    else
    begin
      pre_r     <= pre_nxt;
      div_cnt_r <= div_cnt_nxt;
      slot_r    <= slot_nxt;
      phase_r   <= phase_nxt;
      frame_r   <= frame_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------

  // Brightness window restarts at each 256-clock prescaler wrap, so blank time sits at the end of every prescaler period
  assign pwm_on = (pre_r[PRE_W-1:2] <= cfg_r.led_brightness_level);

  // Outputs are registered from one slot value, so two digits never overlap
  always_comb
  begin
    com_nxt = '0;
    seg_nxt = '0;
    unique case (cfg_r.mode)
      LSD_MODE_DIRECT:
      begin
        com_nxt = data_r[slot_r] & {NUM_COM{pwm_on}};
        for (int i = 0; i < MAX_DIG; i++)
        begin
          seg_nxt[i] = (slot_r == 4'(i)) && pwm_on;
        end
      end
      LSD_MODE_EXT:
      begin
        for (int c = 0; c < NUM_COM; c++)
        begin
          com_nxt[c] = ((slot_r == 4'(c)) && pwm_on) ^ cfg_r.common_polarity;
        end
        // All 32 lanes driven; the matrix size limits which ones a board wires
        for (int i = 0; i < NUM_SEG; i++)
        begin
          seg_nxt[i] = (data_r[i][slot_r[2:0]] && pwm_on) ^ cfg_r.segment_polarity;
        end
      end
      LSD_MODE_LCD:
      begin
        // Digital stand-in for the glass waveform: second half frame inverted
        for (int c = 0; c < NUM_COM; c++)
        begin
          com_nxt[c] = (slot_r == 4'(c)) ^ phase_r;
        end
        for (int i = 0; i < NUM_SEG; i++)
        begin
          seg_nxt[i] = data_r[i][slot_r[2:0]] ^ phase_r;
        end
      end
      LSD_MODE_OFF:
      begin
        com_nxt = '0;
        seg_nxt = '0;
      end
    endcase
    // Blank drives every com and seg pin to its inactive level; sequencer is untouched
    if (cfg_r.display_blank)
    begin
      com_nxt = (cfg_r.mode == LSD_MODE_EXT) ? {NUM_COM{cfg_r.common_polarity}} : '0;
      seg_nxt = (cfg_r.mode == LSD_MODE_EXT) ? {NUM_SEG{cfg_r.segment_polarity}} : '0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      com_r <= '0;
      seg_r <= '0;
    end
    else
    begin
      com_r <= com_nxt;
      seg_r <= seg_nxt;
    end
  end

  // Every output comes straight from a flip-flop
  assign com_out     = com_r;
  assign seg_out     = seg_r;
  assign frame_pulse = frame_r;
  assign reg_rdata   = rdata_r;

endmodule

`default_nettype wire

/* File: verification/lsd_scan_driver_properties.sv */
// Checker: port-level properties of the scan driver
`default_nettype none
module lsd_scan_driver_props
  import lsd_pkg::*;
#(parameter int NUM_SEG = 32)(
  // Clock, reset and register port
  input wire logic               clk_sys,
  input wire logic               sys_rst,
  input wire logic [ADDR_W-1:0]  reg_addr,
  input wire logic [DATA_W-1:0]  reg_wdata,
  input wire logic               reg_wr,
  input wire logic               reg_rd,
  input wire logic [DATA_W-1:0]  reg_rdata,
  // Display pins
  input wire logic [NUM_COM-1:0] com_out,
  input wire logic [NUM_SEG-1:0] seg_out,
  input wire logic               frame_pulse
);
  // ----------
  // Shadow state
  // ----------
  logic [1:0] mode_r;
  logic       blk_r;
  logic       cpol_r;
  logic       spol_r;
  logic [5:0] brt_r;
  logic [1:0] st_r;
  logic       ok;
  // Pins lag a write by two cycles, so checks wait for three quiet cycles
  always_ff @(posedge clk_sys)
    if (sys_rst)
      {mode_r, blk_r, cpol_r, spol_r, brt_r, st_r} <= '0;
    else
    begin
      if (reg_wr && reg_addr == ADDR_DIVH) mode_r <= reg_wdata[6:5];
      if (reg_wr && reg_addr == ADDR_CFG) blk_r <= reg_wdata[3];
      if (reg_wr && reg_addr == ADDR_POL) {spol_r, cpol_r} <= reg_wdata[7:6];
      if (reg_wr && reg_addr == ADDR_POL) brt_r <= reg_wdata[5:0];
      st_r <= reg_wr ? 2'h0 : (st_r == 2'h3 ? st_r : st_r + 2'h1);
    end
  assign ok = (st_r == 2'h3);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == '0) else $error("read data not idle");
  AST_UNMAPPED: assert property (reg_rd && reg_addr > ADDR_STAT |=> reg_rdata == '0) else $error("unmapped read");
  AST_FRAME_ONE: assert property (frame_pulse |=> !frame_pulse [*8]) else $error("frame pulse long");
  AST_BLANK_LED: assert property (ok && blk_r && mode_r != LSD_MODE_EXT |-> com_out == '0 && seg_out == '0)
    else $error("blank pins active");
  AST_BLANK_EXT: assert property (ok && blk_r && mode_r == LSD_MODE_EXT
    |-> com_out == {NUM_COM{cpol_r}} && seg_out == {NUM_SEG{spol_r}}) else $error("blank ext pins");
  // Below full brightness the PWM gap darkens every digit, so one-hot needs level 63
  AST_DIRECT_DIG: assert property (ok && !blk_r && mode_r == LSD_MODE_DIRECT && brt_r == 6'h3f
    |-> $onehot(seg_out[MAX_DIG-1:0]) && seg_out[NUM_SEG-1:MAX_DIG] == '0) else $error("digit select");
  AST_DIRECT_ONE0: assert property (ok && !blk_r && mode_r == LSD_MODE_DIRECT
    |-> $onehot0(seg_out[MAX_DIG-1:0])) else $error("two digits lit");
  AST_EXT_COM: assert property (ok && !blk_r && mode_r == LSD_MODE_EXT
    |-> $onehot0(com_out ^ {NUM_COM{cpol_r}})) else $error("ext commons");
  AST_LCD_COM: assert property (ok && !blk_r && mode_r == LSD_MODE_LCD
    |-> $countones(com_out) inside {0, 1, 7, 8}) else $error("lcd commons");
  AST_SLOT_HOLD: assert property (ok && mode_r == LSD_MODE_DIRECT && brt_r == 6'h3f && $changed(seg_out)
    |=> ($stable(seg_out) || !ok) [*8]) else $error("slot too short");
  C_FRAME: cover property (frame_pulse);
  C_BLANK: cover property (ok && blk_r && mode_r == LSD_MODE_EXT);
  C_DIRECT: cover property (ok && mode_r == LSD_MODE_DIRECT && seg_out[2]);
endmodule
bind lsd_scan_driver lsd_scan_driver_props #(.NUM_SEG(NUM_SEG)) u_props (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .com_out(com_out), .seg_out(seg_out), .frame_pulse(frame_pulse));
`default_nettype wire

/* File: verification/lsd_led_array_model.sv */
// LED array stand-in: pattern each digit receives and the frame period
`default_nettype none
module lsd_led_array_model
  import lsd_pkg::*;
(
  // Pins seen from the glass
  input wire logic               clk_sys,
  input wire logic [NUM_COM-1:0] com_out,
  input wire logic [31:0]        seg_out,
  input wire logic               frame_pulse
);
  logic [7:0] pat [MAX_DIG];
  int         n_frm = 0;
  int         per = 0;
  int         cnt = 0;
  initial
    foreach (pat[i]) pat[i] = 8'h00;
  // A digit latches what the commons carry while its line is selected
  always @(posedge clk_sys)
  begin
    for (int d = 0; d < MAX_DIG; d++)
      if (seg_out == 32'h1 << d) pat[d] <= com_out;
    cnt <= frame_pulse ? 1 : cnt + 1;
    if (frame_pulse)
    begin
      per <= cnt;
      n_frm <= n_frm + 1;
    end
  end
endmodule
`default_nettype wire

/* File: verification/test_led_lcd_scan_driver.sv */
// Bench: register port, LED direct/external and LCD scan timing
`default_nettype none
module test_led_lcd_scan_driver
  import lsd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk_sys = 1'b0;
  logic              sys_rst = 1'b1;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic [DATA_W-1:0] reg_rdata;
  logic [7:0]        com_out;
  logic [31:0]       seg_out;
  logic              frame_pulse;
  logic [7:0]        exp_pat [4] = '{8'h81, 8'h42, 8'h24, 8'h00};
  int                n_errors = 0;
  int                checked = 0;
  int                cyc = 0;
  lsd_scan_driver DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .com_out(com_out), .seg_out(seg_out),
    .frame_pulse(frame_pulse));
  lsd_led_array_model u_glass (.clk_sys(clk_sys), .com_out(com_out), .seg_out(seg_out),
    .frame_pulse(frame_pulse));
  // ----------
  // Access tasks
  // ----------
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] exp, input string nm);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    chk(nm, {24'h0, exp}, {24'h0, reg_rdata});
  endtask
  // Skip the frame cut short by the change, then measure a whole one
  task automatic frames(input int exp, input string nm);
    int n0;
    n0 = u_glass.n_frm;
    for (int i = 0; i < 5 * exp && u_glass.n_frm < n0 + 3; i++) @(posedge clk_sys);
    @(negedge clk_sys);
    // A frame count short of three means the wait ran out
    chk({nm, "_count"}, n0 + 3, u_glass.n_frm);
    chk(nm, exp, u_glass.per);
  endtask
  task automatic pins(input logic [7:0] c, input logic [31:0] s, input string nm);
    for (int i = 0; i < 2000 && com_out !== c; i++) @(negedge clk_sys);
    // Commons still off target means the wait ran out
    chk({nm, "_com"}, {24'h0, c}, {24'h0, com_out});
    chk(nm, s, seg_out);
  endtask
  // Clock and hang guard
  initial
    forever #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      n_errors++;
      tally_and_finish();
    end
  end
  // Main sequence
  initial
  begin
    repeat (12) @(posedge clk_sys);
    sys_rst <= 1'b0;
    for (int i = 0; i < 6; i++) rd(ADDR_DIVL + 6'(i), 8'h00, "reg_reset");
    chk("pins_reset", 0, seg_out | {24'h0, com_out});
    wr(ADDR_DIVH, 8'hff);
    rd(ADDR_DIVH, 8'h6f, "divh_reserved");
    wr(6'h26, 8'ha5);
    rd(6'h26, 8'h00, "unmapped");
    $display("test registers done");
    for (int i = 0; i < 3; i++) wr(6'(i), exp_pat[i]);
    wr(ADDR_POL, 8'h3f); wr(ADDR_DIVL, 8'h00); wr(ADDR_SCAN, 8'h02);
    wr(ADDR_DIVH, 8'h60);
    frames(768, "direct_frame");
    for (int d = 0; d < 4; d++) chk("digit_pattern", exp_pat[d], u_glass.pat[d]);
    wr(ADDR_SCAN, 8'h0f);
    frames(3840, "direct_clamp");
    $display("test direct done");
    wr(ADDR_DIVH, 8'h00); wr(6'h00, 8'h02); wr(ADDR_SCAN, 8'h01);
    wr(6'h1f, 8'h02);
    wr(ADDR_POL, 8'h7e);
    wr(ADDR_DIVH, 8'h40);
    pins(8'hfe, 32'h0, "ext_slot0");
    pins(8'hfd, 32'h80000003, "ext_slot1");
    frames(512, "ext_frame");
    wr(ADDR_CFG, 8'h08);
    repeat (3) @(posedge clk_sys);
    pins(8'hff, 32'h0, "blank_pins");
    frames(512, "blank_frame");
    $display("test external done");
    wr(ADDR_CFG, 8'h00); wr(ADDR_SCAN, 8'h05); wr(ADDR_DIVH, 8'h20);
    frames(3072, "lcd_frame");
    wr(ADDR_DIVH, 8'h00);
    repeat (3) @(posedge clk_sys);
    pins(8'h00, 32'h0, "off_pins");
    $display("test lcd done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
